// *** hw/mcic_top.v ***
// Interrupt aggregation for the motion card
`timescale 1ns/100ps
`default_nettype none
`include "mcic_consts.vh"
module mcic_top (
    // Clock and reset
    input wire clk,
    input wire resetn,
    // Configuration
    input wire six_axis_mode,
    input wire int_enable,
    // Mask write
    input wire mask_wr,
    input wire [`MCIC_SRC_W-1:0] mask_sel,
    input wire [`MCIC_MASK_W-1:0] mask_data,
    // Status read
    input wire status_rd,
    input wire [`MCIC_SRC_W-1:0] status_sel,
    output reg [`MCIC_MASK_W-1:0] status_data_r,
    output reg status_valid_r,
    // Condition inputs, one word per axis plus system and I/O
    input wire [`MCIC_AXES*`MCIC_MASK_W-1:0] axis_cond,
    input wire [`MCIC_MASK_W-1:0] sys_cond,
    input wire [`MCIC_MASK_W-1:0] io_cond,
    // Host handshake
    input wire handler_busy,
    output reg int_req_r,
    output reg int_event_r
);
// ----------------------------------------
// Reset release
// ----------------------------------------
reg rst_q1_r;
reg rst_q2_r;
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        rst_q1_r <= 1'b0;
        rst_q2_r <= 1'b0;
    end else begin
        rst_q1_r <= 1'b1;
        rst_q2_r <= rst_q1_r;
    end
end
wire rst_n = rst_q2_r;
// ----------------------------------------
// Input synchronisers for pin-level conditions and handler busy
// ----------------------------------------
localparam NW = `MCIC_NSRC*`MCIC_MASK_W;
reg [NW-1:0] cond_s1_r;
reg [NW-1:0] cond_s2_r;
reg busy_s1_r;
reg busy_s2_r;
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        cond_s1_r <= {NW{1'b0}};
        cond_s2_r <= {NW{1'b0}};
        busy_s1_r <= 1'b0;
        busy_s2_r <= 1'b0;
    end else begin
        cond_s1_r <= {io_cond & `MCIC_IO_BITS, sys_cond & `MCIC_SYS_BITS,
                      axis_cond};
        cond_s2_r <= cond_s1_r;
        busy_s1_r <= handler_busy;
        busy_s2_r <= busy_s1_r;
    end
end
// ----------------------------------------
// Selector to internal slot
// ----------------------------------------
// Slots: 0-11 axes, 12 system, 13 I/O; 15 means no source
function [3:0] slot_of;
    input [3:0] sel;
    input six;
    begin
        if (six) begin
            if (sel < `MCIC_AXES_6)
                slot_of = sel; // RULE11
            else if (sel == `MCIC_SYS_SEL_6)
                slot_of = `MCIC_SYS_SEL_12; // RULE11
            else if (sel == `MCIC_IO_SEL_6)
                slot_of = `MCIC_IO_SEL_12; // RULE11
            else
                slot_of = 4'hf;
        end else begin
            // Selectors 0-11 axes, 12 system, 13 I/O
            if (sel <= `MCIC_IO_SEL_12)
                slot_of = sel; // RULE5 RULE9
            else
                slot_of = 4'hf;
        end
    end
endfunction
wire [3:0] wr_slot = slot_of(mask_sel, six_axis_mode);
wire [3:0] rd_slot = slot_of(status_sel, six_axis_mode);
// ----------------------------------------
// Bits each slot may hold
// ----------------------------------------
// Axis words keep all 16 bits; system and I/O words keep only their
// defined bits, so an undefined bit can never latch or request.
function [`MCIC_MASK_W-1:0] keep_bits;
    input [3:0] slot;
    begin
        case (slot)
            `MCIC_SYS_SEL_12: keep_bits = `MCIC_SYS_BITS; // RULE9
            `MCIC_IO_SEL_12: keep_bits = `MCIC_IO_BITS; // RULE10
            default: keep_bits = `MCIC_AXIS_BITS; // RULE6 RULE7 RULE8
        endcase
    end
endfunction
// ----------------------------------------
// Write and read strobes per slot
// ----------------------------------------
// A selector that maps to no slot gives an all-zero strobe, so an
// unmapped write is dropped and an unmapped read returns zero.
reg [`MCIC_NSRC-1:0] wr_hit;
reg [`MCIC_NSRC-1:0] rd_hit;
integer d;
always @* begin
    wr_hit = {`MCIC_NSRC{1'b0}};
    rd_hit = {`MCIC_NSRC{1'b0}};
    for (d = 0; d < `MCIC_NSRC; d = d + 1) begin
        wr_hit[d] = mask_wr && (wr_slot == d); // RULE4
        rd_hit[d] = status_rd && (rd_slot == d); // RULE15
    end
end
// ----------------------------------------
// Condition masks
// ----------------------------------------
reg [`MCIC_MASK_W-1:0] mask_r [0:`MCIC_NSRC-1];
integer m;
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        for (m = 0; m < `MCIC_NSRC; m = m + 1) begin
            mask_r[m] <= `MCIC_MASK_RST;
        end
    end else begin
        for (m = 0; m < `MCIC_NSRC; m = m + 1) begin
            if (wr_hit[m]) begin
                mask_r[m] <= mask_data & keep_bits(m[3:0]); // RULE4
            end
        end
    end
end
// ----------------------------------------
// Latched status
// ----------------------------------------
// A condition arriving in the cycle of the read that clears its word
// is kept: the set wins, otherwise that interrupt would be lost.
reg [`MCIC_MASK_W-1:0] stat_r [0:`MCIC_NSRC-1];
integer s;
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        for (s = 0; s < `MCIC_NSRC; s = s + 1) begin
            stat_r[s] <= `MCIC_MASK_RST;
        end
    end else begin
        for (s = 0; s < `MCIC_NSRC; s = s + 1) begin
            stat_r[s] <= (rd_hit[s] ? `MCIC_STAT_CLR : stat_r[s]) | // RULE15
                (cond_s2_r[s*`MCIC_MASK_W +: `MCIC_MASK_W] & mask_r[s]); // RULE2
        end
    end
end
// ----------------------------------------
// Status read-out
// ----------------------------------------
// Data reads as zero outside its valid cycle, so the host side never
// has to qualify it before use.
reg [`MCIC_MASK_W-1:0] status_data_nxt;
integer r;
always @* begin
    status_data_nxt = `MCIC_MASK_RST;
    for (r = 0; r < `MCIC_NSRC; r = r + 1) begin
        if (rd_hit[r]) begin
            status_data_nxt = stat_r[r]; // RULE15
        end
    end
end
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        status_data_r <= `MCIC_MASK_RST;
        status_valid_r <= 1'b0;
    end else begin
        status_data_r <= status_data_nxt;
        status_valid_r <= status_rd; // RULE15
    end
end
// ----------------------------------------
// Pending summary
// ----------------------------------------
reg [`MCIC_NSRC-1:0] any_nxt;
integer a;
always @* begin
    any_nxt = {`MCIC_NSRC{1'b0}};
    for (a = 0; a < `MCIC_NSRC; a = a + 1) begin
        any_nxt[a] = |stat_r[a]; // RULE3 RULE16
    end
end
// ----------------------------------------
// Request and event
// ----------------------------------------
// A request is raised only while the host handler is idle, so a new
// one waits until the previous handler has finished. A fresh event
// needs the request to fall and rise again.
wire pend = (|any_nxt) & int_enable; // RULE16 RULE1
reg int_req_nxt;
reg int_event_nxt;
always @* begin
    int_req_nxt = int_req_r;
    int_event_nxt = 1'b0;
    if (!int_enable) begin
        int_req_nxt = 1'b0; // RULE1
    end else if (!int_req_r) begin
        if (pend && !busy_s2_r) begin
            int_req_nxt = 1'b1; // RULE2 RULE12 RULE13
            int_event_nxt = 1'b1; // RULE14
        end
    end else if (!pend) begin
        int_req_nxt = 1'b0; // RULE15
    end
end
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        int_req_r <= 1'b0;
        int_event_r <= 1'b0;
    end else begin
        int_req_r <= int_req_nxt;
        int_event_r <= int_event_nxt;
    end
end
endmodule // mcic_top
`default_nettype wire

// *** hw/mcic_consts.vh ***
// Constants for the motion card interrupt control block
// Notes on behaviour
// (RULE1) Switch off means no request at all
// (RULE2) Request needs switch on and enabled condition
// (RULE3) Sources are axes, I/O and system
// (RULE4) Mask write touches only the selected source
// (RULE5) Twelve-axis: selectors 0-11 are axes
// (RULE6) Axis mask bits 0-12 per listed conditions
// (RULE7) Axis bit 13 is deviation excess
// (RULE8) Axis bits 14, 15 are compare channels
// (RULE9) Twelve-axis: selector 12 is system source
// (RULE10) I/O bits 0,1 inputs; 8-10 counters
// (RULE11) Six-axis: axes 0-5, system 6, I/O 7
// (RULE12) One request line per card
// (RULE13) Next request held until handler done
// (RULE14) Host event once per raised interrupt
// (RULE15) Latched status, cleared by its read
// (RULE16) Request is OR of latched bits, gated
`ifndef MCIC_CONSTS_VH
`define MCIC_CONSTS_VH
`define MCIC_AXES 12
`define MCIC_SRC_W 4
`define MCIC_MASK_W 16
`define MCIC_NSRC 14
`define MCIC_SYS_SEL_12 4'h0c
`define MCIC_IO_SEL_12 4'h0d
`define MCIC_SYS_SEL_6 4'h6
`define MCIC_IO_SEL_6 4'h7
`define MCIC_AXES_6 4'h6
`define MCIC_SYS_BITS 16'h0007
`define MCIC_IO_BITS 16'h0703
`define MCIC_MASK_RST 16'h0000
`define MCIC_STAT_CLR 16'h0000
`define MCIC_AXIS_BITS 16'hffff
`endif

// *** dv/mcic_props.sv ***
// Port assertions for the interrupt control block
`timescale 1ns/100ps
`default_nettype none
module mcic_props (
    // Watched ports
    input wire logic clk,
    input wire logic resetn,
    input wire logic int_enable,
    input wire logic handler_busy,
    input wire logic status_rd,
    input wire logic [15:0] status_data_r,
    input wire logic status_valid_r,
    input wire logic int_req_r,
    input wire logic int_event_r
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_off_req: assert property (!int_enable[*4] |-> !int_req_r)
        else $error("req off");
    a_req_gate: assert property ($rose(int_req_r) |-> $past(int_enable))
        else $error("req gate");
    a_busy_hold: assert property (handler_busy[*4] |=> !$rose(int_req_r))
        else $error("req busy");
    a_event_edge: assert property (int_event_r |-> $rose(int_req_r))
        else $error("event edge");
    a_event_one: assert property (int_event_r |=> !int_event_r)
        else $error("event long");
    a_read_ans: assert property (status_rd |=> status_valid_r)
        else $error("no answer");
    a_valid_src: assert property (status_valid_r |-> $past(status_rd))
        else $error("stray valid");
    a_data_idle: assert property (!status_valid_r |-> !status_data_r)
        else $error("data idle");
    cover property (int_event_r);
    cover property (status_valid_r && status_data_r != 16'h0);
    cover property (handler_busy && int_req_r);
endmodule // mcic_props
bind mcic_top mcic_props u_props (.*);
`default_nettype wire

// *** dv/mcic_host.sv ***
// Host model: handler stays busy a few cycles per event
`timescale 1ns/100ps
`default_nettype none
module mcic_host (
    // Card side
    input wire logic clk,
    input wire logic int_event_r,
    output wire logic handler_busy
);
    int left = 0;
    assign handler_busy = left > 0;
    always @(posedge clk) begin
        left <= int_event_r === 1'b1 ? 5 : left - (left > 0);
    end
endmodule // mcic_host
`default_nettype wire

// *** dv/mcic_top_tb.sv ***
// Self-checking bench for the interrupt control block
`timescale 1ns/100ps
`default_nettype none
module mcic_top_tb;
    logic clk = 0, rst_n = 0, six = 0, en = 0, wr = 0, rd = 0;
    logic req, evt, bz, sv;
    logic [3:0] ws = 0, rs = 0;
    logic [15:0] wd = 0, c = 0, sd, k, e, q[$];
    int n_errors = 0, n_compared = 0, nx = 0, ne = 0, s, n;
    mcic_top DUT (.clk(clk), .resetn(rst_n), .six_axis_mode(six),
        .int_enable(en), .mask_wr(wr), .mask_sel(ws), .mask_data(wd),
        .status_rd(rd), .status_sel(rs), .status_data_r(sd),
        .status_valid_r(sv), .axis_cond({12{c}}), .sys_cond(c),
        .io_cond(c), .handler_busy(bz), .int_req_r(req),
        .int_event_r(evt));
    mcic_host host (.clk(clk), .int_event_r(evt), .handler_busy(bz));
    initial forever #25 clk = ~clk;
    task automatic chk(string nm, logic [15:0] v, x);
        n_compared++;
        if (v !== x) begin
            n_errors++;
            $display("BAD %s exp %h seen %h", nm, x, v);
        end
    endtask
    task automatic step(int m);
        repeat (m) @(posedge clk);
        #1;
    endtask
    task automatic wm(logic [3:0] a, logic [15:0] d);
        wr = 1;
        ws = a;
        wd = d;
        step(1);
    endtask
    task automatic report_and_stop;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk) begin
        ne += evt === 1'b1;
        if (sv === 1'b1) chk("status", sd, q.pop_front());
    end
    initial begin
        #200000 n_errors++;
        report_and_stop;
    end
    initial begin
        void'($urandom(32'h2235));
        step(16);
        rst_n = 1;
        step(3);
        for (int t = 0; t < 32; t++) begin
            six = t[4];
            s = t % 16;
            n = six ? 6 : 12;
            k = $urandom;
            c = $urandom;
            e = c & k & (s < n ? 16'hffff : s == n ? 16'h0007 :
                s == n + 1 ? 16'h0703 : 16'h0);
            wm(s[3:0], k);
            wm(4'hf, 16'hffff); // Unmapped, must be ignored
            wr = 0;
            step(6);
            chk("off", {15'h0, req}, 16'h0);
            en = 1;
            step(8);
            chk("on", {15'h0, req}, {15'h0, e != 0});
            nx += e != 0;
            c = 0;
            step(4);
            rd = 1;
            for (int j = 0; j < 16; j++) begin
                rs = j[3:0];
                q.push_back(j == s ? e : 16'h0);
                step(1);
            end
            rd = 0;
            step(4);
            chk("clr", {15'h0, req}, 16'h0);
            en = 0;
            wm(s[3:0], 16'h0);
            wr = 0;
            $display("test %0d", t);
        end
        chk("events", ne[15:0], nx[15:0]);
        n = q.size();
        chk("unanswered", n[15:0], 16'h0000);
        report_and_stop;
    end
endmodule // mcic_top_tb
`default_nettype wire
